// [core/plc_consts.vh]
// constants of the link control register bank and its serial frame engine
`ifndef PLC_CONSTS_VH
`define PLC_CONSTS_VH

// register addresses on the management serial interface
`define PLC_REG_CTRL 5'h17
`define PLC_REG_MASK 5'h18
`define PLC_REG_STAT 5'h19

// link and line control fields
`define PLC_CTRL_LINK_BIT 13
`define PLC_CTRL_DS_HI 12
`define PLC_CTRL_DS_LO 10
`define PLC_CTRL_PARTNER_BIT 7
`define PLC_CTRL_JABBER_BIT 6
`define PLC_CTRL_HEART_BIT 5
`define PLC_CTRL_ECHO_BIT 4
`define PLC_CTRL_PRE_HI 3
`define PLC_CTRL_PRE_LO 2
`define PLC_CTRL_FORCE_BIT 0

// interrupt enable mask and event status fields
`define PLC_MASK_TDR_BIT 10
`define PLC_MASK_SYNC_BIT 9
`define PLC_MASK_PIN_BIT 0

// reset values
`define PLC_RST_LINK 1'b1
`define PLC_RST_DS 3'h4
`define PLC_RST_JABBER 1'b1
`define PLC_RST_HEART 1'b0
`define PLC_RST_ECHO 1'b0
`define PLC_RST_PRE 2'h2
`define PLC_RST_FORCE 1'b0
`define PLC_RST_MASK 1'b0

// serial frame fields
`define PLC_OP_WRITE 2'h1
`define PLC_OP_READ 2'h2
`define PLC_HDR_BITS 4'hc
`define PLC_DATA_BITS 4'hf
`define PLC_FULL_PREAMBLE 5'h1f

`endif

// [core/plc_event_latch.v]
// latching read-only flag: set wins over a read clear
module plc_event_latch (
    input wire clk_sys, // system clock
    input wire rst, // synchronous reset, active high
    input wire setEvt, // event seen this cycle
    input wire holdCond, // condition still present
    input wire clrRead, // flag was returned by a read
    output reg flag_q // latched flag
);

    wire flag_d;

    // a read clears the flag only once the condition has gone
    assign flag_d = setEvt | (flag_q & (~clrRead | holdCond));

    always @(posedge clk_sys) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule // plc_event_latch

// [core/plc_link_ctrl_regs.v]
// link and line control registers behind the management serial interface
//
// Overview of operation
// - While link allow is set the transceiver tries to bring a link up and watches the line for link pulses.
// - With link allow clear the transceiver drops any link, goes to standby and ignores partner link pulses.
// - In standby the cable reflection test and the powered-phone detect stay usable.
// - Link allow resets to one, a written zero disables linking and a written one enables it.
// - Bits 12:10 give the failed attempts before a speed downshift as value plus one, resetting to five.
// - While linking is disabled a partner appearing sets and holds the read-only flag at bit 7.
// - Bit 6 at one turns off jabber protection, at zero keeps it, and resets to one.
// - Bit 5 at one enables the heartbeat, at zero suppresses it, and resets to zero.
// - Bit 4 at one suppresses twisted-pair echo in half duplex and resets to zero.
// - Bits 3:2 pick a preamble of zero, one, two or seven bytes and reset to two bytes.
// - Bit 0 of the control register at one asserts the interrupt pin, at zero leaves it to the enabled pending events, reset zero.
// - Mask bits 10 and 9 let the test-complete and sync-lost events raise an interrupt, both reset zero.
// - The interrupt pin is active low and is pulled low on an enabled pending event when pin enable is one.
// - A lost frame synchronisation is flagged and is recovered by one frame with a full preamble.
`include "plc_consts.vh"

module plc_link_ctrl_regs #(
    parameter [4:0] PHY_ADDR = 5'h01 // station address on the serial bus
) (
    input wire clk_sys, // system clock
    input wire rst, // synchronous reset, active high
    input wire mdc, // management clock, sampled
    input wire mdioIn, // management data from the pin
    output reg mdioOut, // management data to the pin
    output reg mdioOeN, // low while this end drives the data pin
    output reg mgmtIrqPinOut, // interrupt pin level when driven
    output reg mgmtIrqPinOeN, // low while the interrupt pin is pulled
    input wire partnerSeen, // line sees a partner
    input wire cableTestReq, // request a cable reflection test
    input wire phoneDetReq, // request a powered-phone detect
    input wire testDone, // pulse: test or phone detect complete
    output wire linkAttempt, // try to bring a link up
    output wire linkPulseAccept, // link pulses are acted on
    output wire standby, // link dropped, standby
    output reg cableTestGo, // cable reflection test started
    output reg phoneDetGo, // phone detect started
    output wire [3:0] downshiftTries, // attempts before downshift
    output wire jabberOff, // jabber protection disabled
    output wire heartbeatEnable, // heartbeat enabled
    output wire pairEchoSuppress, // twisted-pair echo suppressed
    output reg [2:0] preambleBytes, // preamble bytes sent
    output wire syncLost // pulse: frame synchronisation lost
);

    ////////////////////////////////////////////////////////////////////////
    // frame engine states, one-hot

    localparam [4:0] S_HUNT = 5'h01;
    localparam [4:0] S_IDLE = 5'h02;
    localparam [4:0] S_HDR = 5'h04;
    localparam [4:0] S_TA = 5'h08;
    localparam [4:0] S_DATA = 5'h10;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;
    reg [12:0] hdr_q;
    reg [12:0] hdr_d;
    reg [15:0] shift_q;
    reg [15:0] shift_d;
    reg isRead_q;
    reg isRead_d;
    reg hit_q;
    reg hit_d;
    reg [4:0] regAddr_q;
    reg [4:0] regAddr_d;
    reg mdcPrev_q;
    reg syncBad;
    reg readNow;
    reg writeNow;
    reg [15:0] writeWord;

    wire mdcRise;
    wire mdcFall;
    wire [12:0] hdrFull;
    wire [1:0] hdrOp;

    ////////////////////////////////////////////////////////////////////////
    // register storage

    reg linkAllow_q;
    reg [2:0] dsAttempts_q;
    reg jabberOff_q;
    reg heartbeat_q;
    reg pairEcho_q;
    reg [1:0] preamble_q;
    reg forceIrq_q;
    reg maskTdr_q;
    reg maskSync_q;
    reg pinEnable_q;
    reg [15:0] readWord;

    wire partnerFlag;
    wire tdrFlag;
    wire syncFlag;
    wire readCtrl;
    wire readStat;
    wire irqPending;

    assign mdcRise = mdc & ~mdcPrev_q;
    assign mdcFall = ~mdc & mdcPrev_q;
    assign hdrFull = {hdr_q[11:0], mdioIn};
    assign hdrOp = hdrFull[11:10];

    ////////////////////////////////////////////////////////////////////////
    // serial frame engine: sampled on the rising management clock

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        shift_d = shift_q;
        isRead_d = isRead_q;
        hit_d = hit_q;
        regAddr_d = regAddr_q;
        syncBad = 1'b0;
        readNow = 1'b0;
        writeNow = 1'b0;
        writeWord = {shift_q[14:0], mdioIn};
        if (mdcRise) begin
            case (state_q)
                S_HUNT: begin
                    // only a full run of ones re-arms the engine
                    if (!mdioIn) begin
                        cnt_d = 5'h00;
                    end else if (cnt_q == `PLC_FULL_PREAMBLE) begin
                        state_d = S_IDLE;
                        cnt_d = 5'h00;
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                S_IDLE: begin
                    // the first zero is the start pattern, with or
                    // without a preamble ahead of it
                    if (!mdioIn) begin
                        state_d = S_HDR;
                        cnt_d = 5'h00;
                    end
                end
                S_HDR: begin
                    hdr_d = hdrFull;
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q[3:0] == `PLC_HDR_BITS) begin
                        cnt_d = 5'h00;
                        if (!hdrFull[12] || (hdrOp != `PLC_OP_READ &&
                                hdrOp != `PLC_OP_WRITE)) begin
                            syncBad = 1'b1;
                            state_d = S_HUNT;
                        end else begin
                            state_d = S_TA;
                            isRead_d = (hdrOp == `PLC_OP_READ);
                            hit_d = (hdrFull[9:5] == PHY_ADDR);
                            regAddr_d = hdrFull[4:0];
                            if (hdrOp == `PLC_OP_READ) begin
                                shift_d = readWord;
                                readNow = (hdrFull[9:5] == PHY_ADDR);
                            end
                        end
                    end
                end
                S_TA: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q != 5'h00) begin
                        state_d = S_DATA;
                        cnt_d = 5'h00;
                    end
                end
                S_DATA: begin
                    cnt_d = cnt_q + 5'h01;
                    if (!isRead_q) begin
                        shift_d = writeWord;
                    end
                    if (cnt_q[3:0] == `PLC_DATA_BITS) begin
                        state_d = S_IDLE;
                        cnt_d = 5'h00;
                        writeNow = hit_q & ~isRead_q;
                    end
                end
                default: begin
                    state_d = S_HUNT;
                    cnt_d = 5'h00;
                end
            endcase
        end else if (mdcFall && state_q == S_DATA && isRead_q) begin
            shift_d = {shift_q[14:0], 1'b0};
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= S_HUNT;
            cnt_q <= 5'h00;
            hdr_q <= 13'h0000;
            shift_q <= 16'h0000;
            isRead_q <= 1'b0;
            hit_q <= 1'b0;
            regAddr_q <= 5'h00;
            mdcPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            shift_q <= shift_d;
            isRead_q <= isRead_d;
            hit_q <= hit_d;
            regAddr_q <= regAddr_d;
            mdcPrev_q <= mdc;
        end
    end

    // read data changes on the falling clock so it is stable at the rise
    always @(posedge clk_sys) begin
        if (rst) begin
            mdioOut <= 1'b1;
            mdioOeN <= 1'b1;
        end else if (mdcFall) begin
            if (state_q == S_TA && cnt_q != 5'h00 && isRead_q && hit_q) begin
                mdioOut <= 1'b0;
                mdioOeN <= 1'b0;
            end else if (state_q == S_DATA && isRead_q && hit_q) begin
                mdioOut <= shift_q[15];
                mdioOeN <= 1'b0;
            end else begin
                mdioOut <= 1'b1;
                mdioOeN <= 1'b1;
            end
        end
    end

    assign syncLost = syncBad;

    ////////////////////////////////////////////////////////////////////////
    // register file

    always @* begin
        readWord = 16'h0000;
        case (hdrFull[4:0])
            `PLC_REG_CTRL: begin
                readWord[`PLC_CTRL_LINK_BIT] = linkAllow_q;
                readWord[`PLC_CTRL_DS_HI:`PLC_CTRL_DS_LO] = dsAttempts_q;
                readWord[`PLC_CTRL_PARTNER_BIT] = partnerFlag;
                readWord[`PLC_CTRL_JABBER_BIT] = jabberOff_q;
                readWord[`PLC_CTRL_HEART_BIT] = heartbeat_q;
                readWord[`PLC_CTRL_ECHO_BIT] = pairEcho_q;
                readWord[`PLC_CTRL_PRE_HI:`PLC_CTRL_PRE_LO] = preamble_q;
                readWord[`PLC_CTRL_FORCE_BIT] = forceIrq_q;
            end
            `PLC_REG_MASK: begin
                readWord[`PLC_MASK_TDR_BIT] = maskTdr_q;
                readWord[`PLC_MASK_SYNC_BIT] = maskSync_q;
                readWord[`PLC_MASK_PIN_BIT] = pinEnable_q;
            end
            `PLC_REG_STAT: begin
                readWord[`PLC_MASK_TDR_BIT] = tdrFlag;
                readWord[`PLC_MASK_SYNC_BIT] = syncFlag;
            end
            default: begin
                readWord = 16'h0000;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            linkAllow_q <= `PLC_RST_LINK;
            dsAttempts_q <= `PLC_RST_DS;
            jabberOff_q <= `PLC_RST_JABBER;
            heartbeat_q <= `PLC_RST_HEART;
            pairEcho_q <= `PLC_RST_ECHO;
            preamble_q <= `PLC_RST_PRE;
            forceIrq_q <= `PLC_RST_FORCE;
            maskTdr_q <= `PLC_RST_MASK;
            maskSync_q <= `PLC_RST_MASK;
            pinEnable_q <= `PLC_RST_MASK;
        end else if (writeNow) begin
            // the partner flag and reserved bits take no write
            if (regAddr_q == `PLC_REG_CTRL) begin
                linkAllow_q <= writeWord[`PLC_CTRL_LINK_BIT];
                dsAttempts_q <=
                    writeWord[`PLC_CTRL_DS_HI:`PLC_CTRL_DS_LO];
                jabberOff_q <= writeWord[`PLC_CTRL_JABBER_BIT];
                heartbeat_q <= writeWord[`PLC_CTRL_HEART_BIT];
                pairEcho_q <= writeWord[`PLC_CTRL_ECHO_BIT];
                preamble_q <=
                    writeWord[`PLC_CTRL_PRE_HI:`PLC_CTRL_PRE_LO];
                forceIrq_q <= writeWord[`PLC_CTRL_FORCE_BIT];
            end else if (regAddr_q == `PLC_REG_MASK) begin
                maskTdr_q <= writeWord[`PLC_MASK_TDR_BIT];
                maskSync_q <= writeWord[`PLC_MASK_SYNC_BIT];
                pinEnable_q <= writeWord[`PLC_MASK_PIN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched flags

    assign readCtrl = readNow & (hdrFull[4:0] == `PLC_REG_CTRL);
    assign readStat = readNow & (hdrFull[4:0] == `PLC_REG_STAT);

    plc_event_latch partnerLatch (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvt(partnerSeen & ~linkAllow_q),
        .holdCond(partnerSeen & ~linkAllow_q),
        .clrRead(readCtrl),
        .flag_q(partnerFlag)
    );

    plc_event_latch tdrLatch (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvt(testDone),
        .holdCond(1'b0),
        .clrRead(readStat),
        .flag_q(tdrFlag)
    );

    plc_event_latch syncLatch (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvt(syncBad),
        .holdCond(1'b0),
        .clrRead(readStat),
        .flag_q(syncFlag)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin: open drain, pulled low when asserted

    assign irqPending = (tdrFlag & maskTdr_q) | (syncFlag & maskSync_q);

    always @(posedge clk_sys) begin
        if (rst) begin
            mgmtIrqPinOut <= 1'b0;
            mgmtIrqPinOeN <= 1'b1;
        end else begin
            mgmtIrqPinOut <= 1'b0;
            // forcing overrides the pin enable
            mgmtIrqPinOeN <= ~(forceIrq_q |
                (pinEnable_q & irqPending));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line control outputs

    assign linkAttempt = linkAllow_q;
    assign linkPulseAccept = linkAllow_q;
    assign standby = ~linkAllow_q;
    assign downshiftTries = {1'b0, dsAttempts_q} + 4'h1;
    assign jabberOff = jabberOff_q;
    assign heartbeatEnable = heartbeat_q;
    assign pairEchoSuppress = pairEcho_q;

    // tests run whatever the link allow state, standby included
    always @(posedge clk_sys) begin
        if (rst) begin
            cableTestGo <= 1'b0;
            phoneDetGo <= 1'b0;
            preambleBytes <= 3'h2;
        end else begin
            cableTestGo <= cableTestReq;
            phoneDetGo <= phoneDetReq;
            case (preamble_q)
                2'h0: preambleBytes <= 3'h0;
                2'h1: preambleBytes <= 3'h1;
                2'h2: preambleBytes <= 3'h2;
                default: preambleBytes <= 3'h7;
            endcase
        end
    end

endmodule // plc_link_ctrl_regs

// [sim/plc_link_ctrl_regs_asserts.sv]
// port assertions for the link and line control register bank
module plc_link_ctrl_regs_asserts (
    input logic clk_sys, // clock
    input logic rst, // reset
    input logic mdc, // serial clock
    input logic mdioOut, // data out
    input logic mdioOeN, // data drive
    input logic mgmtIrqPinOut, // irq level
    input logic mgmtIrqPinOeN, // irq pull
    input logic cableTestReq, // test request
    input logic phoneDetReq, // detect request
    input logic testDone, // test done
    input logic linkAttempt, // link try
    input logic linkPulseAccept, // pulses used
    input logic standby, // standby
    input logic cableTestGo, // test start
    input logic phoneDetGo, // detect start
    input logic [3:0] downshiftTries, // tries
    input logic jabberOff, // jabber off
    input logic heartbeatEnable, // heartbeat
    input logic pairEchoSuppress, // echo off
    input logic [2:0] preambleBytes, // preamble
    input logic syncLost // sync lost
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    a_link_follow: assert property (
        linkPulseAccept == linkAttempt && standby != linkAttempt)
        else $error("link outputs disagree");
    a_reset_vals: assert property (
        $fell(rst) |-> linkAttempt && downshiftTries == 4'h5 && jabberOff
        && !heartbeatEnable && !pairEchoSuppress && preambleBytes == 3'h2
        && mgmtIrqPinOeN)
        else $error("wrong value after reset");
    a_ds_range: assert property (
        downshiftTries != 4'h0 && downshiftTries <= 4'h8)
        else $error("downshift tries out of range");
    a_pre_code: assert property (
        preambleBytes inside {3'h0, 3'h1, 3'h2, 3'h7})
        else $error("illegal preamble length");
    a_test_copy: assert property (
        !linkAttempt |=> cableTestGo == $past(cableTestReq)
        && phoneDetGo == $past(phoneDetReq))
        else $error("test start lost in standby");
    a_irq_open: assert property (
        mgmtIrqPinOut == 1'b0)
        else $error("irq pin driven high");
    // the pin moves only after a frame or an event, never on its own
    a_irq_cause: assert property (
        $changed(mgmtIrqPinOeN) |-> $past(mdc) || $past(mdc, 2)
        || $past(testDone, 2) || $past(syncLost, 2))
        else $error("irq pin moved without cause");
    a_ta_zero: assert property (
        $fell(mdioOeN) |-> !mdioOut && !mdc)
        else $error("turnaround not driven low");
    a_sync_pulse: assert property (
        syncLost |-> mdioOeN ##1 !syncLost)
        else $error("sync loss not a clean pulse");
endmodule // plc_link_ctrl_regs_asserts

// [sim/plc_mdio_master.sv]
// station management controller model: serial frames on mdc and data
module plc_mdio_master (
    input logic clk_sys, // clock
    output logic mdc, // serial clock
    output logic mdioIn, // resolved line
    input logic mdioOut, // device data
    input logic mdioOeN // device drive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    logic bitQ = 1'b1;
    logic [15:0] rdQ = 16'h0000;
    initial mdc = 1'b0;
    // pulled up when nobody drives, so a released line reads one
    assign mdioIn = drv ? bitQ : (!mdioOeN ? mdioOut : 1'b1);
    ////////////////////////////////////////////////////////////
    // each phase of mdc lasts three system clocks, above the minimum
    task automatic tx(input logic b, input logic own);
        @(posedge clk_sys) mdc <= 1'b0;
        drv <= own;
        bitQ <= b;
        repeat (3) @(posedge clk_sys);
        mdc <= 1'b1;
        if (!own)
            rdQ <= {rdQ[14:0], mdioIn};
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd, input int pre,
        output logic [15:0] rd);
        logic [13:0] hdr;
        logic [17:0] tail;
        hdr = {2'b01, op, phy, ra};
        tail = {2'b10, wd};
        repeat (pre) tx(1'b1, 1'b1);
        for (int i = 13; i >= 0; i--)
            tx(hdr[i], 1'b1);
        for (int i = 17; i >= 0; i--)
            tx(tail[i], op != 2'b10);
        // clock parked low between frames
        @(posedge clk_sys) mdc <= 1'b0;
        drv <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd = rdQ;
    endtask
endmodule // plc_mdio_master

// [sim/plc_link_ctrl_regs_test.sv]
// self-checking bench for the link and line control register bank
`include "plc_consts.vh"
module plc_link_ctrl_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic partnerSeen = 1'b0, cableTestReq = 1'b0;
    logic phoneDetReq = 1'b0, testDone = 1'b0, sawSync = 1'b0;
    logic mdc, mdioIn, mdioOut, mdioOeN, mgmtIrqPinOut, mgmtIrqPinOeN;
    logic linkAttempt, linkPulseAccept, standby, cableTestGo, phoneDetGo;
    logic jabberOff, heartbeatEnable, pairEchoSuppress, syncLost;
    logic [3:0] downshiftTries;
    logic [2:0] preambleBytes, v;
    logic [15:0] rd;
    int num_errors = 0;
    int n_checks = 0;
    plc_link_ctrl_regs uut (.clk_sys(clk_sys), .rst(rst), .mdc(mdc),
        .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
        .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOeN(mgmtIrqPinOeN),
        .partnerSeen(partnerSeen), .cableTestReq(cableTestReq),
        .phoneDetReq(phoneDetReq), .testDone(testDone),
        .linkAttempt(linkAttempt), .linkPulseAccept(linkPulseAccept),
        .standby(standby), .cableTestGo(cableTestGo),
        .phoneDetGo(phoneDetGo), .downshiftTries(downshiftTries),
        .jabberOff(jabberOff), .heartbeatEnable(heartbeatEnable),
        .pairEchoSuppress(pairEchoSuppress), .preambleBytes(preambleBytes),
        .syncLost(syncLost));
    plc_mdio_master sm (.clk_sys(clk_sys), .mdc(mdc), .mdioIn(mdioIn),
        .mdioOut(mdioOut), .mdioOeN(mdioOeN));
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (syncLost === 1'b1) sawSync <= 1'b1;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input int p);
        sm.frame(2'b01, 5'h01, ra, d, p, rd);
    endtask
    task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
        sm.frame(2'b10, 5'h01, ra, 16'h0000, 32, rd);
        check(rd, e);
    endtask
    task automatic pulse_done;
        testDone <= 1'b1;
        @(posedge clk_sys) testDone <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(`PLC_REG_CTRL, 16'h3048);
        rdc(`PLC_REG_MASK, 16'h0000);
        $display("reset values done");
        // reserved and read-only bits written as ones must read zero
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            wr(`PLC_REG_CTRL, {3'b111, v, 3'b111, v, v[1:0], 2'b10}, 32);
            rdc(`PLC_REG_CTRL, {3'b001, v, 3'b000, v, v[1:0], 2'b00});
            check(downshiftTries, {1'b0, v} + 4'h1);
            check(preambleBytes, (v[1:0] == 2'b11) ? 3'h7 : v[1:0]);
            check(jabberOff, v[2]);
            check(heartbeatEnable, v[1]);
            check(pairEchoSuppress, v[0]);
        end
        $display("field sweep done");
        wr(`PLC_REG_CTRL, 16'h0000, 32);
        check({linkAttempt, linkPulseAccept, standby}, 3'b001);
        cableTestReq <= 1'b1;
        phoneDetReq <= 1'b1;
        partnerSeen <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({cableTestGo, phoneDetGo}, 2'b11);
        rdc(`PLC_REG_CTRL, 16'h0080);
        partnerSeen <= 1'b0;
        rdc(`PLC_REG_CTRL, 16'h0080);
        rdc(`PLC_REG_CTRL, 16'h0000);
        cableTestReq <= 1'b0;
        phoneDetReq <= 1'b0;
        wr(`PLC_REG_CTRL, 16'h2000, 32);
        check({linkAttempt, standby}, 2'b10);
        check({cableTestGo, phoneDetGo}, 2'b00);
        partnerSeen <= 1'b1;
        rdc(`PLC_REG_CTRL, 16'h2000);
        partnerSeen <= 1'b0;
        $display("link allow done");
        wr(`PLC_REG_CTRL, 16'h2001, 32);
        check(mgmtIrqPinOeN, 1'b0);
        wr(`PLC_REG_CTRL, 16'h2000, 32);
        check(mgmtIrqPinOeN, 1'b1);
        wr(`PLC_REG_MASK, 16'hffff, 32);
        rdc(`PLC_REG_MASK, 16'h0601);
        pulse_done();
        check(mgmtIrqPinOeN, 1'b0);
        rdc(`PLC_REG_STAT, 16'h0400);
        check(mgmtIrqPinOeN, 1'b1);
        wr(`PLC_REG_MASK, 16'h0600, 32);
        pulse_done();
        check(mgmtIrqPinOeN, 1'b1);
        rdc(`PLC_REG_STAT, 16'h0400);
        $display("interrupt pin done");
        wr(`PLC_REG_MASK, 16'h0201, 32);
        sm.frame(2'b11, 5'h01, `PLC_REG_CTRL, 16'h2020, 32, rd);
        check(sawSync, 1'b1);
        check(mgmtIrqPinOeN, 1'b0);
        wr(`PLC_REG_CTRL, 16'h2020, 0);
        check(heartbeatEnable, 1'b0);
        wr(`PLC_REG_CTRL, 16'h2020, 32);
        check(heartbeatEnable, 1'b1);
        rdc(`PLC_REG_STAT, 16'h0200);
        check(mgmtIrqPinOeN, 1'b1);
        $display("sync recovery done");
        // a reset in mid-run must bring every default back, link allow too
        wr(`PLC_REG_CTRL, 16'h0001, 32);
        check(mgmtIrqPinOeN, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(`PLC_REG_CTRL, 16'h3048);
        rdc(`PLC_REG_MASK, 16'h0000);
        check({linkAttempt, standby, mgmtIrqPinOeN}, 3'b101);
        $display("mid-run reset done");
        end_sim();
    end
endmodule // plc_link_ctrl_regs_test
bind plc_link_ctrl_regs plc_link_ctrl_regs_asserts chk (.clk_sys(clk_sys),
    .rst(rst), .mdc(mdc), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
    .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOeN(mgmtIrqPinOeN),
    .cableTestReq(cableTestReq), .phoneDetReq(phoneDetReq),
    .testDone(testDone), .linkAttempt(linkAttempt),
    .linkPulseAccept(linkPulseAccept), .standby(standby),
    .cableTestGo(cableTestGo), .phoneDetGo(phoneDetGo),
    .downshiftTries(downshiftTries), .jabberOff(jabberOff),
    .heartbeatEnable(heartbeatEnable), .pairEchoSuppress(pairEchoSuppress),
    .preambleBytes(preambleBytes), .syncLost(syncLost));
